// *** pkg/adw_pkg.sv ***
// Purpose: shared constants and types for the dma wait and address block
// Assumes: 8-bit I/O data, 16-bit I/O addresses, 24-bit system address
// Notes: offsets are I/O port addresses
package adw_pkg;
   // ------------------------------------------------------------
   // indexed configuration access
   // ------------------------------------------------------------
   localparam logic [15:0] ADW_PORT_INDEX = 16'h0022;
   localparam logic [15:0] ADW_PORT_DATA = 16'h0023;
   localparam logic [7:0] ADW_IDX_CLOCK_WAIT = 8'h01;
   localparam logic [7:0] ADW_CLOCK_WAIT_RST = 8'h00;
   localparam logic [7:0] ADW_INDEX_RST = 8'h00;
   // ------------------------------------------------------------
   // dma_clock_wait_control field positions
   // ------------------------------------------------------------
   localparam int ADW_CPU_WAIT_HI = 7;
   localparam int ADW_CPU_WAIT_LO = 6;
   localparam int ADW_WORD_WAIT_HI = 5;
   localparam int ADW_WORD_WAIT_LO = 4;
   localparam int ADW_BYTE_WAIT_HI = 3;
   localparam int ADW_BYTE_WAIT_LO = 2;
   localparam int ADW_EARLY_MEMR = 1;
   localparam int ADW_CLOCK_SEL = 0;
   // ------------------------------------------------------------
   // dma controller ports
   // ------------------------------------------------------------
   localparam logic [11:0] ADW_BYTE_REG_HI = 12'h000;
   localparam logic [11:0] ADW_WORD_REG_HI = 12'h00C;
   localparam logic [15:0] ADW_BYTE_PTR_CMD = 16'h000C;
   localparam logic [15:0] ADW_BYTE_MCLR = 16'h000D;
   localparam logic [15:0] ADW_WORD_PTR_CMD = 16'h00D8;
   localparam logic [15:0] ADW_WORD_MCLR = 16'h00DA;
   localparam logic [2:0] ADW_CASCADE_CH = 3'd4;
   localparam logic [15:0] ADW_CHAN_REG_RST = 16'h0000;
   localparam logic [23:0] ADW_SYS_ADDR_RST = 24'h00_0000;
   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef struct packed {
      logic [15:0] addr;
      logic rd;
      logic wr;
      logic [7:0] wdata;
   } adw_io_t;
endpackage

// *** rtl/adw_fifo.sv ***
// Purpose: flip-flop fifo with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes: full and empty come from a word count
`timescale 1ns/1ps
module adw_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_rst_b,
   // fill side
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   // drain side
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wp_r;
   logic [AW-1:0] rp_r;
   logic [AW:0] cnt_r;
   logic push;
   logic pop;

   assign o_in_ready = (cnt_r != (AW+1)'(DEPTH));
   assign o_out_valid = (cnt_r != '0);
   assign o_out_data = mem_r[rp_r];
   assign push = i_in_valid && o_in_ready;
   assign pop = o_out_valid && i_out_ready;

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_r[wp_r] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         wp_r <= '0;
         rp_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wp_r <= wp_r + 1'b1;
         end
         if (pop) begin
            rp_r <= rp_r + 1'b1;
         end
         cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// *** rtl/adw_top.sv ***
// Purpose: dma clock/wait control, dma channel programming and address generation
// Assumes: page byte and dma state strobes come from the surrounding dma engine
// Notes: at bus clock and hold acknowledge are pins, synchronized by three flops and filtered by a fourth
// Overview of operation
// - bits 7:6 pick cpu cycle wait states: 01 two, 10 three
// - bits 5:4 word, 3:2 byte dma waits: 00 one, 01 two, 10 three
// - bit 1 clear delays memory read one dma clock; set asserts both together
// - bit 0 clear runs dma at half bus clock, set at full rate
// - four byte channels, word channel 0 is cascade, three word channels
// - programming accepted only after hold acknowledge inactive one dma clock
// - byte pointer picks low/high byte, toggles on each address/count access
// - byte pointer cleared by reset and master clear, set/cleared by command
// - in S1 intermediate address byte goes to internal lines and is latched, except on the cascade channel
// - byte channels: low on A0-A7, latched on A8-A15, page on A16-A23
// - word channels: low on A1-A8, latched on A9-A16, page on A17-A23
`timescale 1ns/1ps
module adw_top
   import adw_pkg::*;
#(
   parameter int FIFO_WIDTH = 16,
   parameter int FIFO_DEPTH = 8
) (
   // clock and reset
   input wire logic I_CLK_SYS,
   input wire logic I_RST_B,
   // cpu i/o access
   input wire adw_io_t I_IO,
   output logic [7:0] O_IO_RDATA,
   // pins
   input wire logic I_AT_BUS_CLOCK,
   input wire logic I_HOLD_ACKNOWLEDGE,
   // dma engine strobes
   input wire logic I_DMA_S1,
   input wire logic [2:0] I_DMA_CHAN,
   input wire logic [7:0] I_DMA_PAGE,
   input wire logic I_DMA_RD_CMD,
   // timing outputs
   output logic O_DMA_TICK,
   output logic [1:0] O_CPU_WAIT,
   output logic [1:0] O_WORD_DMA_WAIT,
   output logic [1:0] O_BYTE_DMA_WAIT,
   output logic O_IO_READ_B,
   output logic O_MEM_READ_B,
   output logic [23:0] O_SYS_ADDR,
   // dma data path
   input wire logic I_DIN_VALID,
   output logic O_DIN_READY,
   input wire logic [FIFO_WIDTH-1:0] I_DIN_DATA,
   output logic O_DOUT_VALID,
   input wire logic I_DOUT_READY,
   output logic [FIFO_WIDTH-1:0] O_DOUT_DATA
);
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!I_RST_B);

   // ------------------------------------------------------------
   // pin filters
   // ------------------------------------------------------------
   logic [1:0] pin_in;
   logic [1:0] s1_r;
   logic [1:0] s2_r;
   logic [1:0] s3_r;
   logic [1:0] flt_r;
   assign pin_in = {I_HOLD_ACKNOWLEDGE, I_AT_BUS_CLOCK};

   for (genvar g = 0; g < 2; g++) begin : g_pin
      always_ff @(posedge I_CLK_SYS) begin
         if (!I_RST_B) begin
            s1_r[g] <= 1'b0;
            s2_r[g] <= 1'b0;
            s3_r[g] <= 1'b0;
            flt_r[g] <= 1'b0;
         end else begin
            s1_r[g] <= pin_in[g];
            s2_r[g] <= s1_r[g];
            s3_r[g] <= s2_r[g];
            if (s2_r[g] == s3_r[g]) begin
               flt_r[g] <= s3_r[g];
            end
         end
      end
   end

   logic bclk_f;
   logic hold_acknowledge_f;
   logic bclk_d_r;
   logic rise;
   assign bclk_f = flt_r[0];
   assign hold_acknowledge_f = flt_r[1];
   assign rise = bclk_f && !bclk_d_r;

   // ------------------------------------------------------------
   // configuration register
   // ------------------------------------------------------------
   logic [7:0] idx_r;
   logic [7:0] cw_r;
   logic cfg_sel;
   assign cfg_sel = (idx_r == ADW_IDX_CLOCK_WAIT);

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         idx_r <= ADW_INDEX_RST;
         cw_r <= ADW_CLOCK_WAIT_RST;
      end else if (I_IO.wr) begin
         if (I_IO.addr == ADW_PORT_INDEX) begin
            idx_r <= I_IO.wdata;
         end else if (I_IO.addr == ADW_PORT_DATA && cfg_sel) begin
            cw_r <= I_IO.wdata;
         end
      end
   end

   // ------------------------------------------------------------
   // wait states
   // ------------------------------------------------------------
   function automatic logic [1:0] wait_of(input logic [1:0] code);
      wait_of = (code == 2'b00) ? 2'd1 : ((code == 2'b01) ? 2'd2 : 2'd3);
   endfunction

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         O_CPU_WAIT <= 2'd1;
         O_WORD_DMA_WAIT <= 2'd1;
         O_BYTE_DMA_WAIT <= 2'd1;
      end else begin
         O_CPU_WAIT <= wait_of(cw_r[ADW_CPU_WAIT_HI:ADW_CPU_WAIT_LO]);
         O_WORD_DMA_WAIT <= wait_of(cw_r[ADW_WORD_WAIT_HI:ADW_WORD_WAIT_LO]);
         O_BYTE_DMA_WAIT <= wait_of(cw_r[ADW_BYTE_WAIT_HI:ADW_BYTE_WAIT_LO]);
      end
   end

   // ------------------------------------------------------------
   // dma clock
   // ------------------------------------------------------------
   logic div_r;
   logic tick;
   assign tick = rise && (cw_r[ADW_CLOCK_SEL] || div_r);

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         bclk_d_r <= 1'b0;
         div_r <= 1'b0;
         O_DMA_TICK <= 1'b0;
      end else begin
         bclk_d_r <= bclk_f;
         if (rise) begin
            div_r <= !div_r;
         end
         O_DMA_TICK <= tick;
      end
   end

   // ------------------------------------------------------------
   // read strobes
   // ------------------------------------------------------------
   logic seen_r;
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         seen_r <= 1'b0;
         O_IO_READ_B <= 1'b1;
         O_MEM_READ_B <= 1'b1;
      end else begin
         seen_r <= I_DMA_RD_CMD && (seen_r || tick);
         O_IO_READ_B <= !I_DMA_RD_CMD;
         if (cw_r[ADW_EARLY_MEMR]) begin
            O_MEM_READ_B <= !I_DMA_RD_CMD;
         end else begin
            O_MEM_READ_B <= !(I_DMA_RD_CMD && seen_r);
         end
      end
   end

   // ------------------------------------------------------------
   // programming enable
   // ------------------------------------------------------------
   // hold must stay low across one whole dma clock, tick to tick, before programming opens
   logic prog_en_r;
   logic hold_low_r;
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         hold_low_r <= 1'b0;
         prog_en_r <= 1'b0;
      end else if (hold_acknowledge_f) begin
         hold_low_r <= 1'b0;
         prog_en_r <= 1'b0;
      end else if (tick) begin
         hold_low_r <= 1'b1;
         prog_en_r <= hold_low_r;
      end
   end

   // ------------------------------------------------------------
   // channel registers and byte pointers
   // ------------------------------------------------------------
   logic [15:0] addr_r [8];
   logic [15:0] cnt_r [8];
   logic [1:0] ptr_r;
   logic hit_b;
   logic hit_w;
   logic [2:0] ch;
   logic is_cnt;
   logic ctl;
   logic acc;
   logic [15:0] cur;
   assign hit_b = (I_IO.addr[15:4] == ADW_BYTE_REG_HI) && !I_IO.addr[3];
   assign hit_w = (I_IO.addr[15:4] == ADW_WORD_REG_HI) && !I_IO.addr[0];
   assign ch = hit_w ? {1'b1, I_IO.addr[3:2]} : {1'b0, I_IO.addr[2:1]};
   assign is_cnt = hit_w ? I_IO.addr[1] : I_IO.addr[0];
   assign ctl = hit_w;
   assign acc = prog_en_r && (I_IO.rd || I_IO.wr) && (hit_b || hit_w);
   assign cur = is_cnt ? cnt_r[ch] : addr_r[ch];

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         ptr_r <= 2'b00;
      end else if (acc) begin
         ptr_r[ctl] <= !ptr_r[ctl];
      end else if (prog_en_r && I_IO.wr) begin
         if (I_IO.addr == ADW_BYTE_PTR_CMD) begin
            ptr_r[0] <= I_IO.wdata[0];
         end else if (I_IO.addr == ADW_WORD_PTR_CMD) begin
            ptr_r[1] <= I_IO.wdata[0];
         end else if (I_IO.addr == ADW_BYTE_MCLR) begin
            ptr_r[0] <= 1'b0;
         end else if (I_IO.addr == ADW_WORD_MCLR) begin
            ptr_r[1] <= 1'b0;
         end
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         for (int i = 0; i < 8; i++) begin
            addr_r[i] <= ADW_CHAN_REG_RST;
            cnt_r[i] <= ADW_CHAN_REG_RST;
         end
      end else if (acc && I_IO.wr) begin
         if (is_cnt && ptr_r[ctl]) begin
            cnt_r[ch][15:8] <= I_IO.wdata;
         end else if (is_cnt) begin
            cnt_r[ch][7:0] <= I_IO.wdata;
         end else if (ptr_r[ctl]) begin
            addr_r[ch][15:8] <= I_IO.wdata;
         end else begin
            addr_r[ch][7:0] <= I_IO.wdata;
         end
      end
   end

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         O_IO_RDATA <= 8'h00;
      end else if (I_IO.rd) begin
         if (I_IO.addr == ADW_PORT_DATA) begin
            O_IO_RDATA <= cfg_sel ? cw_r : 8'h00;
         end else if (acc) begin
            O_IO_RDATA <= ptr_r[ctl] ? cur[15:8] : cur[7:0];
         end else if (I_IO.addr == ADW_PORT_INDEX) begin
            O_IO_RDATA <= idx_r;
         end else begin
            O_IO_RDATA <= 8'h00;
         end
      end
   end

   // ------------------------------------------------------------
   // address generation
   // ------------------------------------------------------------
   logic [7:0] internal_dma_data_lines;
   logic [7:0] mid_r;
   logic s1_ok;
   logic word_ch;
   assign internal_dma_data_lines = addr_r[I_DMA_CHAN][15:8];
   assign s1_ok = I_DMA_S1 && (I_DMA_CHAN != ADW_CASCADE_CH);
   assign word_ch = I_DMA_CHAN[2];

   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_B) begin
         mid_r <= 8'h00;
         O_SYS_ADDR <= ADW_SYS_ADDR_RST;
      end else if (s1_ok) begin
         mid_r <= internal_dma_data_lines;
         if (word_ch) begin
            O_SYS_ADDR <= {I_DMA_PAGE[7:1], internal_dma_data_lines,
                           addr_r[I_DMA_CHAN][7:0], 1'b0};
         end else begin
            O_SYS_ADDR <= {I_DMA_PAGE, internal_dma_data_lines,
                           addr_r[I_DMA_CHAN][7:0]};
         end
      end
   end

   // ------------------------------------------------------------
   // data buffer
   // ------------------------------------------------------------
   adw_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
      .i_clk(I_CLK_SYS),
      .i_rst_b(I_RST_B),
      .i_in_valid(I_DIN_VALID),
      .o_in_ready(O_DIN_READY),
      .i_in_data(I_DIN_DATA),
      .o_out_valid(O_DOUT_VALID),
      .i_out_ready(I_DOUT_READY),
      .o_out_data(O_DOUT_DATA)
   );

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   sequence s_rd_rise;
      $rose(I_DMA_RD_CMD);
   endsequence
   property p_cfg_write;
      I_IO.wr && I_IO.addr == ADW_PORT_DATA && cfg_sel |=> cw_r == $past(I_IO.wdata);
   endproperty
   a_cfg_write: assert property (p_cfg_write) else $error("config write lost");
   property p_cpu_wait;
      cw_r[7:6] == 2'b10 ##1 cw_r[7:6] == 2'b10 |-> O_CPU_WAIT == 2'd3;
   endproperty
   a_cpu_wait: assert property (p_cpu_wait) else $error("cpu wait wrong");
   property p_word_wait;
      cw_r[5:4] == 2'b01 ##1 cw_r[5:4] == 2'b01 |-> O_WORD_DMA_WAIT == 2'd2;
   endproperty
   a_word_wait: assert property (p_word_wait) else $error("word wait wrong");
   property p_late_memr;
      !cw_r[1] ##0 s_rd_rise |=> !O_IO_READ_B && O_MEM_READ_B;
   endproperty
   a_late_memr: assert property (p_late_memr) else $error("memr not delayed");
   property p_early_memr;
      cw_r[1] ##0 s_rd_rise |=> !O_IO_READ_B && !O_MEM_READ_B;
   endproperty
   a_early_memr: assert property (p_early_memr) else $error("memr not early");
   property p_half_clock;
      tick && !cw_r[0] |-> div_r && rise;
   endproperty
   a_half_clock: assert property (p_half_clock) else $error("dma tick rate wrong");
   property p_cascade;
      I_DMA_S1 && I_DMA_CHAN == ADW_CASCADE_CH |=> $stable(O_SYS_ADDR);
   endproperty
   a_cascade: assert property (p_cascade) else $error("cascade channel drove address");
   property p_hold_block;
      hold_acknowledge_f |=> !prog_en_r ##1 !acc;
   endproperty
   a_hold_block: assert property (p_hold_block) else $error("programming during hold");
   property p_ptr_toggle;
      acc |=> ptr_r[$past(ctl)] != $past(ptr_r[ctl]);
   endproperty
   a_ptr_toggle: assert property (p_ptr_toggle) else $error("byte pointer stuck");
   property p_mclr;
      prog_en_r && !acc && I_IO.wr && I_IO.addr == ADW_BYTE_MCLR |=> !ptr_r[0];
   endproperty
   a_mclr: assert property (p_mclr) else $error("master clear missed");
   property p_latch_mid;
      s1_ok |=> mid_r == $past(internal_dma_data_lines);
   endproperty
   a_latch_mid: assert property (p_latch_mid) else $error("intermediate byte lost");
   property p_byte_addr;
      s1_ok && !word_ch |=> O_SYS_ADDR[15:8] == mid_r && O_SYS_ADDR[23:16] == $past(I_DMA_PAGE);
   endproperty
   a_byte_addr: assert property (p_byte_addr) else $error("byte address layout");
   property p_word_addr;
      s1_ok && word_ch |=> O_SYS_ADDR[16:9] == mid_r && !O_SYS_ADDR[0];
   endproperty
   a_word_addr: assert property (p_word_addr) else $error("word address layout");
endmodule

// *** verification/adw_at_peer.sv ***
// Purpose: at bus side model: bus clock, hold, dma strobes, data stream
// Assumes: every change but the free-running bus clock is made at the falling edge of the system clock
// Notes: bus clock runs free; released lines show inverted values
`timescale 1ns/1ps
module adw_at_peer #(
   parameter real BUS_HALF_NS = 20.0
) (
   // system clock
   input wire logic i_clk,
   // stream status from the block
   input wire logic i_din_ready,
   input wire logic i_dout_valid,
   input wire logic [15:0] i_dout_data,
   // pins and dma strobes
   output logic o_bus_clk,
   output logic o_hold,
   output logic o_s1,
   output logic [2:0] o_chan,
   output logic [7:0] o_page,
   output logic o_rd_cmd,
   // stream to and from the block
   output logic o_din_valid,
   output logic [15:0] o_din_data,
   output logic o_dout_ready
);
   // ------
   // pin levels
   // ------
   initial begin
      o_bus_clk = 1'b0;
      o_hold = 1'b0;
      o_s1 = 1'b0;
      o_chan = 3'h0;
      o_page = 8'h00;
      o_rd_cmd = 1'b0;
      o_din_valid = 1'b0;
      o_din_data = 16'h0000;
      o_dout_ready = 1'b0;
   end
   always #(BUS_HALF_NS) o_bus_clk = ~o_bus_clk;
   task automatic hold_set(input logic v);
      @(negedge i_clk);
      o_hold = v;
   endtask
   task automatic rd_set(input logic v);
      @(negedge i_clk);
      o_rd_cmd = v;
   endtask
   // ------
   // dma start, S1 held with channel and page for one system clock
   // ------
   task automatic start_op(input logic [2:0] ch, input logic [7:0] pg);
      @(negedge i_clk);
      o_s1 = 1'b1;
      o_chan = ch;
      o_page = pg;
      @(negedge i_clk);
      o_s1 = 1'b0;
      o_chan = ~ch;
      o_page = ~pg;
   endtask
   // ------
   // stream transfers, held until the edge that takes them
   // ------
   task automatic push(input logic [15:0] d);
      @(negedge i_clk);
      o_din_valid = 1'b1;
      o_din_data = d;
      for (int k = 0; k < 50 && i_din_ready !== 1'b1; k++) begin
         @(negedge i_clk);
      end
      @(negedge i_clk);
      o_din_valid = 1'b0;
      o_din_data = ~d;
   endtask
   task automatic pop(output logic [15:0] d);
      @(negedge i_clk);
      for (int k = 0; k < 50 && i_dout_valid !== 1'b1; k++) begin
         @(negedge i_clk);
      end
      d = i_dout_data;
      o_dout_ready = 1'b1;
      @(negedge i_clk);
      o_dout_ready = 1'b0;
   endtask
endmodule

// *** verification/tb.sv ***
// Purpose: self-checking bench for the dma wait and address block
// Assumes: inputs change at the falling edge of the 200 MHz clock
// Notes: channel readback returns the value last written
`timescale 1ns/1ps
module tb;
   import adw_pkg::*;
   logic clk_sys, rst_b;
   adw_io_t io_req;
   logic [7:0] io_rdata, rd_val, page;
   logic bus_clk, hold, s1, rd_cmd, din_valid, din_ready, dout_valid, dout_ready;
   logic tick, io_read_b, mem_read_b;
   logic [2:0] chan;
   logic [1:0] cpu_wait, word_wait, byte_wait;
   logic [15:0] din_data, dout_data, word;
   logic [23:0] sys_addr;
   int failures, checks_done, n, t_io, t_mem;
   initial clk_sys = 1'b0;
   always #2.5 clk_sys = ~clk_sys;
   adw_top i_dut (
      .I_CLK_SYS(clk_sys),
      .I_RST_B(rst_b),
      .I_IO(io_req),
      .O_IO_RDATA(io_rdata),
      .I_AT_BUS_CLOCK(bus_clk),
      .I_HOLD_ACKNOWLEDGE(hold),
      .I_DMA_S1(s1),
      .I_DMA_CHAN(chan),
      .I_DMA_PAGE(page),
      .I_DMA_RD_CMD(rd_cmd),
      .O_DMA_TICK(tick),
      .O_CPU_WAIT(cpu_wait),
      .O_WORD_DMA_WAIT(word_wait),
      .O_BYTE_DMA_WAIT(byte_wait),
      .O_IO_READ_B(io_read_b),
      .O_MEM_READ_B(mem_read_b),
      .O_SYS_ADDR(sys_addr),
      .I_DIN_VALID(din_valid),
      .O_DIN_READY(din_ready),
      .I_DIN_DATA(din_data),
      .O_DOUT_VALID(dout_valid),
      .I_DOUT_READY(dout_ready),
      .O_DOUT_DATA(dout_data)
   );
   adw_at_peer i_peer (
      .i_clk(clk_sys),
      .i_din_ready(din_ready),
      .i_dout_valid(dout_valid),
      .i_dout_data(dout_data),
      .o_bus_clk(bus_clk),
      .o_hold(hold),
      .o_s1(s1),
      .o_chan(chan),
      .o_page(page),
      .o_rd_cmd(rd_cmd),
      .o_din_valid(din_valid),
      .o_din_data(din_data),
      .o_dout_ready(dout_ready)
   );
   // ------
   // access tasks
   // ------
   task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      io_req.addr = a;
      io_req.wdata = d;
      io_req.wr = 1'b1;
      @(negedge clk_sys);
      io_req.wr = 1'b0;
   endtask
   task automatic rd_chk(input string what, input logic [15:0] a, input logic [7:0] e);
      @(negedge clk_sys);
      io_req.addr = a;
      io_req.rd = 1'b1;
      @(negedge clk_sys);
      io_req.rd = 1'b0;
      @(negedge clk_sys);
      rd_val = io_rdata;
      chk(what, rd_val, e);
   endtask
   task automatic cfg_wr(input logic [7:0] v);
      io_wr(ADW_PORT_INDEX, ADW_IDX_CLOCK_WAIT);
      io_wr(ADW_PORT_DATA, v);
   endtask
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      #100000;
      failures++;
      close_out();
   end
   // ------
   // tests
   // ------
   initial begin
      failures = 0;
      checks_done = 0;
      io_req = '0;
      rst_b = 1'b0;
      repeat (10) @(negedge clk_sys);
      rst_b = 1'b1;
      chk("word_wait", word_wait, 2'h1);
      chk("byte_wait", byte_wait, 2'h1);
      chk("ior_idle", io_read_b, 1'b1);
      chk("memr_idle", mem_read_b, 1'b1);
      io_wr(ADW_PORT_INDEX, ADW_IDX_CLOCK_WAIT);
      rd_chk("cfg_reset", ADW_PORT_DATA, ADW_CLOCK_WAIT_RST);
      for (int c = 0; c < 3; c++) begin
         cfg_wr({c[1:0], c[1:0], c[1:0], 2'h0});
         rd_chk("cfg_data", ADW_PORT_DATA, {c[1:0], c[1:0], c[1:0], 2'h0});
         chk("cpu_wait", cpu_wait, c[1:0] + 2'h1);
         chk("word_wait", word_wait, c[1:0] + 2'h1);
         chk("byte_wait", byte_wait, c[1:0] + 2'h1);
      end
      io_wr(ADW_PORT_INDEX, 8'h02);
      rd_chk("bad_index", ADW_PORT_DATA, 8'h00);
      io_wr(ADW_PORT_DATA, 8'hFF);
      io_wr(ADW_PORT_INDEX, ADW_IDX_CLOCK_WAIT);
      rd_chk("write_ignored", ADW_PORT_DATA, 8'hA8);
      $display("test config done");
      for (int s = 0; s < 2; s++) begin
         cfg_wr({7'h00, s[0]});
         repeat (20) @(negedge clk_sys);
         n = 0;
         repeat (400) begin
            @(negedge clk_sys);
            n += (tick === 1'b1);
         end
         chk("tick_rate", n >= 23 + 25 * s && n <= 27 + 25 * s, 1'b1);
      end
      $display("test dma clock done");
      i_peer.hold_set(1'b1);
      repeat (10) @(negedge clk_sys);
      io_wr(16'h0002, 8'hAA);
      rd_chk("prog_off", 16'h0002, 8'h00);
      i_peer.hold_set(1'b0);
      repeat (30) @(negedge clk_sys);
      io_wr(16'h0002, 8'h34);
      io_wr(16'h0002, 8'h12);
      rd_chk("addr_lo", 16'h0002, 8'h34);
      rd_chk("addr_hi", 16'h0002, 8'h12);
      io_wr(ADW_BYTE_PTR_CMD, 8'h01);
      rd_chk("ptr_set", 16'h0002, 8'h12);
      io_wr(ADW_BYTE_PTR_CMD, 8'h01);
      io_wr(ADW_BYTE_MCLR, 8'h00);
      rd_chk("mclr", 16'h0002, 8'h34);
      io_wr(ADW_BYTE_PTR_CMD, 8'h00);
      rd_chk("ptr_clr", 16'h0002, 8'h34);
      io_wr(ADW_WORD_PTR_CMD, 8'h01);
      io_wr(ADW_WORD_MCLR, 8'h00);
      io_wr(16'h00C4, 8'h34);
      io_wr(16'h00C4, 8'h12);
      rd_chk("word_lo", 16'h00C4, 8'h34);
      $display("test programming done");
      i_peer.start_op(3'h1, 8'h56);
      repeat (2) @(negedge clk_sys);
      chk("byte_addr", sys_addr, 24'h56_1234);
      i_peer.start_op(3'h5, 8'h57);
      repeat (2) @(negedge clk_sys);
      chk("word_addr", sys_addr, {7'h2B, 16'h1234, 1'b0});
      i_peer.start_op(3'h4, 8'h99);
      repeat (2) @(negedge clk_sys);
      chk("cascade", sys_addr, {7'h2B, 16'h1234, 1'b0});
      $display("test address done");
      for (int e = 0; e < 2; e++) begin
         cfg_wr({6'h00, e[0], 1'b1});
         i_peer.rd_set(1'b1);
         t_io = -1;
         t_mem = -1;
         for (int k = 0; k < 40; k++) begin
            @(negedge clk_sys);
            if (t_io < 0 && io_read_b === 1'b0) t_io = k;
            if (t_mem < 0 && mem_read_b === 1'b0) t_mem = k;
         end
         if (e == 1) chk("memr_with_ior", t_io >= 0 && t_mem == t_io, 1'b1);
         else chk("memr_late", t_io >= 0 && t_mem > t_io && t_mem <= t_io + 12, 1'b1);
         i_peer.rd_set(1'b0);
         repeat (4) @(negedge clk_sys);
         chk("ior_off", io_read_b, 1'b1);
         chk("memr_off", mem_read_b, 1'b1);
      end
      $display("test strobes done");
      for (int i = 0; i < 8; i++) i_peer.push(16'hA000 + 16'(i));
      chk("fifo_full", din_ready, 1'b0);
      for (int i = 0; i < 8; i++) begin
         i_peer.pop(word);
         chk("fifo_data", word, 16'hA000 + 16'(i));
      end
      chk("fifo_empty", dout_valid, 1'b0);
      $display("test fifo done");
      close_out();
   end
endmodule
